// File: hw/rffm_pkg.sv
// How it works
// - A precise frequency failure on input ten sets bit 4 of its latch.
// - A guard soak timer failure on input ten sets bit 3 of its latch.
// - A coarse frequency failure on input ten sets bit 2 of its latch.
// - A single cycle failure on input ten sets bit 1 of its latch.
// - A signal absent condition on input ten sets bit 0 of its latch.
// - Gate bit 4 passes or blocks the input zero precise frequency failure.
// - Gate bit 3 passes or blocks the input zero guard soak failure.
// - Gate bit 2 passes or blocks the input zero coarse frequency failure.
// - Gate bit 1 passes or blocks the input zero single cycle failure.
// - A passed failure reaches ref0_isr_event only if input0_irq_gate.
// - The latch records every failure whatever the gate bits hold.
// - Gate bit 0 passes or blocks the input zero signal absent failure.
`default_nettype none
package rffm_pkg;
    // Printed offsets are register indexes; byte address is four times
    localparam int unsigned LATCH10_IDX = 32'h0000_0030;
    localparam int unsigned GATE0_IDX   = 32'h0000_0036;
    localparam logic [7:0]  LATCH10_ADDR = 8'(LATCH10_IDX * 4);
    localparam logic [7:0]  GATE0_ADDR   = 8'(GATE0_IDX * 4);

    // Field positions shared by latch and gate
    localparam int unsigned BIT_PRECISE = 4;
    localparam int unsigned BIT_GUARD   = 3;
    localparam int unsigned BIT_COARSE  = 2;
    localparam int unsigned BIT_SINGLE  = 1;
    localparam int unsigned BIT_ABSENT  = 0;
    localparam int unsigned MON_W       = 5;

    // Values after reset
    localparam logic [4:0] LATCH10_RESET = 5'h00;
    localparam logic [4:0] GATE0_RESET   = 5'h16;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [4:0] fail10;
        logic [4:0] mask0;
        logic [4:0] gated;
        logic       isr_evt;
        logic       awready;
        logic       wready;
        logic       aw_full;
        logic       w_full;
        logic [1:0] wsel;
        logic [7:0] wdata;
        logic       wlane0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } rffm_state_t;

    localparam rffm_state_t STATE_RESET = '{
        fail10: LATCH10_RESET, mask0: GATE0_RESET, gated: 5'h00,
        isr_evt: 1'b0, awready: 1'b1, wready: 1'b1, aw_full: 1'b0,
        w_full: 1'b0, wsel: 2'h0, wdata: 8'h00, wlane0: 1'b0,
        bvalid: 1'b0, bresp: 2'h0, arready: 1'b1, rvalid: 1'b0,
        rresp: 2'h0, rdata: 8'h00};
endpackage
`default_nettype wire

// File: hw/rffm_top.sv
// Design decision made here: the AXI4-Lite register port.
`default_nettype none
module rffm_top
    import rffm_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
)(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [4:0]        ref10_fail_evt,
    input  wire logic [4:0]        ref0_fail_evt,
    input  wire logic              input0_irq_gate,
    output logic [4:0]             ref0_fail_gated,
    output logic                   ref0_isr_event
);

    // Refuse address widths with no bits above bit 7 for the decode to check
    if (ADDR_W < 9)
    begin : g_addr_check
        $error("ADDR_W must be at least 9");
    end

    rffm_state_t st_q;
    rffm_state_t st_d;
    logic        commit;
    logic        wr_latch;
    logic [4:0]  gated_now;

    // Decode a byte address into {gate hit, latch hit}
    function automatic logic [1:0] reg_decode(
        input logic [ADDR_W-1:0] addr
    );
        logic upper_zero;
        upper_zero = (addr[ADDR_W-1:8] == '0) && (addr[1:0] == 2'h0);
        reg_decode = {upper_zero && (addr[7:0] == GATE0_ADDR),
                      upper_zero && (addr[7:0] == LATCH10_ADDR)};
    endfunction

    // Write commits once both address and data are held
    assign commit    = st_q.aw_full && st_q.w_full && !st_q.bvalid;
    assign wr_latch  = commit && st_q.wsel[0] && st_q.wlane0;
    assign gated_now = ref0_fail_evt & st_q.mask0;

    // Next state of monitor paths and bus slave
    always_comb
    begin
        st_d = st_q;

        // Per-monitor gating toward the interrupt status path
        st_d.gated   = gated_now;
        st_d.isr_evt = (|gated_now) && input0_irq_gate;

        // Address and data channels are taken in either order
        if (s_axi_awvalid && st_q.awready)
        begin
            st_d.aw_full = 1'b1;
            st_d.wsel    = reg_decode(s_axi_awaddr);
        end
        if (s_axi_wvalid && st_q.wready)
        begin
            st_d.w_full = 1'b1;
            st_d.wdata  = s_axi_wdata[7:0];
            st_d.wlane0 = s_axi_wstrb[0];
        end

        // Zero written to a latch bit clears it; one leaves it
        if (wr_latch)
        begin
            st_d.fail10 = st_q.fail10 & st_q.wdata[4:0];
        end
        // New failures win over a clear in the same cycle
        st_d.fail10 |= ref10_fail_evt;

        // Gate register write and write answer
        if (commit)
        begin
            if (st_q.wsel[1] && st_q.wlane0)
            begin
                st_d.mask0 = st_q.wdata[4:0];
            end
            st_d.bvalid  = 1'b1;
            st_d.bresp   = (|st_q.wsel) ? RESP_OKAY : RESP_SLVERR;
            st_d.aw_full = 1'b0;
            st_d.w_full  = 1'b0;
        end
        if (st_q.bvalid && s_axi_bready)
        begin
            st_d.bvalid = 1'b0;
        end
        st_d.awready = !st_d.aw_full;
        st_d.wready  = !st_d.w_full;

        // Read channel: one read under way at a time
        if (s_axi_arvalid && st_q.arready)
        begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            unique case (reg_decode(s_axi_araddr))
                2'h1:
                begin
                    st_d.rdata = {3'h0, st_q.fail10};
                    st_d.rresp = RESP_OKAY;
                end
                2'h2:
                begin
                    st_d.rdata = {3'h0, st_q.mask0};
                    st_d.rresp = RESP_OKAY;
                end
                default:
                begin
                    st_d.rdata = 8'h00;
                    st_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= STATE_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready   = st_q.awready;
    assign s_axi_wready    = st_q.wready;
    assign s_axi_bvalid    = st_q.bvalid;
    assign s_axi_bresp     = st_q.bresp;
    assign s_axi_arready   = st_q.arready;
    assign s_axi_rvalid    = st_q.rvalid;
    assign s_axi_rresp     = st_q.rresp;
    assign s_axi_rdata     = {24'h00_0000, st_q.rdata};
    assign ref0_fail_gated = st_q.gated;
    assign ref0_isr_event  = st_q.isr_evt;

    // Checks on the latch, gating and bus answers
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    precise_latch_a:
    assert property (ref10_fail_evt[BIT_PRECISE]
                     |=> st_q.fail10[BIT_PRECISE])
    else $error("precise failure not latched");

    guard_latch_a:
    assert property (ref10_fail_evt[BIT_GUARD] |-> ##1 st_q.fail10[BIT_GUARD])
    else $error("guard soak failure not latched");

    coarse_latch_a:
    assert property (ref10_fail_evt[BIT_COARSE] && wr_latch
                     |=> st_q.fail10[BIT_COARSE])
    else $error("coarse failure lost against a clear");

    single_latch_a:
    assert property (ref10_fail_evt[BIT_SINGLE]
                     |=> st_q.fail10[BIT_SINGLE])
    else $error("single cycle failure not latched");

    absent_latch_a:
    assert property (ref10_fail_evt[BIT_ABSENT]
                     |=> st_q.fail10[BIT_ABSENT])
    else $error("signal absent not latched");

    precise_pass_a:
    assert property (ref0_fail_evt[BIT_PRECISE] && st_q.mask0[BIT_PRECISE]
                     && input0_irq_gate |=> ref0_isr_event
                     && ref0_fail_gated[BIT_PRECISE])
    else $error("enabled precise failure not forwarded");

    gate_block_a:
    assert property ((ref0_fail_evt & st_q.mask0) == 5'h00
                     |=> !ref0_isr_event && ref0_fail_gated == 5'h00)
    else $error("blocked failure reached interrupt path");

    // An enabled failure shows on its gated bit one cycle later
    guard_pass_a:
    assert property (ref0_fail_evt[BIT_GUARD] && st_q.mask0[BIT_GUARD]
                     |=> ref0_fail_gated[BIT_GUARD])
    else $error("enabled guard soak failure not forwarded");

    coarse_pass_a:
    assert property (ref0_fail_evt[BIT_COARSE] && st_q.mask0[BIT_COARSE]
                     |=> ref0_fail_gated[BIT_COARSE])
    else $error("enabled coarse failure not forwarded");

    single_pass_a:
    assert property (ref0_fail_evt[BIT_SINGLE] && st_q.mask0[BIT_SINGLE]
                     |=> ref0_fail_gated[BIT_SINGLE])
    else $error("enabled single cycle failure not forwarded");

    absent_pass_a:
    assert property (ref0_fail_evt[BIT_ABSENT] && st_q.mask0[BIT_ABSENT]
                     |=> ref0_fail_gated[BIT_ABSENT])
    else $error("enabled signal absent not forwarded");

    // A cleared gate bit keeps its gated bit low whatever the input
    precise_block_a:
    assert property (!st_q.mask0[BIT_PRECISE]
                     |=> !ref0_fail_gated[BIT_PRECISE])
    else $error("masked precise failure forwarded");

    guard_block_a:
    assert property (!st_q.mask0[BIT_GUARD]
                     |=> !ref0_fail_gated[BIT_GUARD])
    else $error("masked guard soak failure forwarded");

    coarse_block_a:
    assert property (!st_q.mask0[BIT_COARSE]
                     |=> !ref0_fail_gated[BIT_COARSE])
    else $error("masked coarse failure forwarded");

    single_block_a:
    assert property (!st_q.mask0[BIT_SINGLE]
                     |=> !ref0_fail_gated[BIT_SINGLE])
    else $error("masked single cycle failure forwarded");

    absent_block_a:
    assert property (!st_q.mask0[BIT_ABSENT]
                     |=> !ref0_fail_gated[BIT_ABSENT])
    else $error("masked signal absent forwarded");

    // Any enabled failure with the reference enabled raises the event
    irq_pass_a:
    assert property ((|(ref0_fail_evt & st_q.mask0)) && input0_irq_gate
                     |=> ref0_isr_event)
    else $error("enabled failure did not raise interrupt event");

    ref_gate_a:
    assert property (!input0_irq_gate |=> !ref0_isr_event)
    else $error("reference gate ignored");

    mask_blind_a:
    assert property (ref10_fail_evt != 5'h00
                     |=> (st_q.fail10 & $past(ref10_fail_evt))
                         == $past(ref10_fail_evt))
    else $error("latch depended on gate bits");

    sticky_hold_a:
    assert property (!wr_latch
                     |=> (st_q.fail10 & $past(st_q.fail10))
                         == $past(st_q.fail10))
    else $error("latched bit dropped without a write");

    bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer withdrawn early");

    read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready
                     |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");

    latch_read_a:
    assert property (s_axi_arvalid && s_axi_arready
                     && reg_decode(s_axi_araddr) == 2'h1
                     |=> s_axi_rdata[4:0] == $past(st_q.fail10))
    else $error("latch read does not show latched bits");

    read_upper_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == '0)
    else $error("reserved read bits not zero");

    write_answer_a:
    assert property (commit |=> s_axi_bvalid && s_axi_awready
                     && s_axi_wready)
    else $error("write not answered after commit");

    clear_cov: cover property (wr_latch && ref10_fail_evt == 5'h00);
    latch_set_cov: cover property (wr_latch && ref10_fail_evt != 5'h00);
    gate_write_cov: cover property (commit && st_q.wsel[1]);
    irq_cov: cover property (ref0_isr_event);
    unmapped_cov: cover property (s_axi_rvalid
                                  && s_axi_rresp == RESP_SLVERR);

endmodule // rffm_top
`default_nettype wire

// File: tb/tb_ref_fail_flag_masking.sv
`default_nettype none
module tb_ref_fail_flag_masking
    import rffm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [11:0] awaddr  = 12'h000;
    logic [11:0] araddr  = 12'h000;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [4:0]  ev10    = 5'h00;
    logic [4:0]  ev0     = 5'h00;
    logic [4:0]  hold10  = 5'h00;
    logic        gate_in = 1'b0;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic        isr;
    logic [31:0] rdata;
    logic [4:0]  gated;
    logic [4:0]  m_latch = 5'h00;
    logic [4:0]  m_mask  = GATE0_RESET;
    logic [4:0]  eg      = 5'h00;
    logic        ei      = 1'b0;
    logic        quiet   = 1'b1;
    logic        chk_on  = 1'b0;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles  = 0;
    integer      seed    = 32'hb95623d2;

    rffm_top #(.ADDR_W(12)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ref10_fail_evt(ev10), .ref0_fail_evt(ev0),
        .input0_irq_gate(gate_in), .ref0_fail_gated(gated),
        .ref0_isr_event(isr));

    always #12.5 ref_clk = ~ref_clk;

    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Monitor inputs go quiet two edges before any bus access
    task automatic hush();
        quiet = 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    function automatic logic mapped(input logic [11:0] a);
        return a == 12'(LATCH10_ADDR) || a == 12'(GATE0_ADDR);
    endfunction

    // Write; the model follows once the response is accepted
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        hush();
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", mapped(a) ? RESP_OKAY : RESP_SLVERR, bresp);
        chk("awready", 32'h0000_0001, awready);
        chk("wready", 32'h0000_0001, wready);
        // Failures held during the write still set after the clear
        if (s[0] && a == 12'(LATCH10_ADDR))
            m_latch = (m_latch & d[4:0]) | ev10;
        if (s[0] && a == 12'(GATE0_ADDR)) m_mask = d[4:0];
        quiet = 1'b0;
    endtask

    // Read and compare with the model's register image
    task automatic rd(input logic [11:0] a);
        logic [31:0] ed;
        hush();
        ed = a == 12'(LATCH10_ADDR) ? 32'(m_latch) :
             a == 12'(GATE0_ADDR) ? 32'(m_mask) : 32'h0000_0000;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk("arready", 32'h0000_0000, arready);
        chk("rresp", mapped(a) ? RESP_OKAY : RESP_SLVERR, rresp);
        chk("rdata", ed, rdata);
        quiet = 1'b0;
    endtask

    // Random monitor failures and reference enable
    always @(posedge ref_clk)
    begin
        ev10    <= !rst_n ? 5'h00 : quiet ? hold10 : 5'($random(seed));
        ev0     <= (rst_n && !quiet) ? 5'($random(seed)) : 5'h00;
        gate_in <= (rst_n && !quiet) ? 1'($random(seed)) : 1'b0;
    end

    // Model of latch and gating; gating compared every cycle, latch on reads
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            chk_on = 1'b0;
        else
        begin
            if (chk_on) chk("gated", eg, gated);
            if (chk_on) chk("isr", ei, isr);
            eg = ev0 & m_mask;
            ei = (|eg) & gate_in;
            m_latch |= ev10;
            chk_on = 1'b1;
        end
    end

    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            end_sim();
        end
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(12'(LATCH10_ADDR));
        rd(12'(GATE0_ADDR));
        // Latch records failures whatever the gate holds
        for (int i = 0; i < 6; i++)
        begin
            wr(12'(GATE0_ADDR), 32'($random(seed)) & 32'h0000_001F,
               4'hF);
            wr(12'(LATCH10_ADDR), 32'h0000_0000, 4'hF);
            repeat (i) @(posedge ref_clk);
            rd(12'(LATCH10_ADDR));
        end
        // Each gate bit alone, then random gate values
        for (int i = 0; i < 10; i++)
        begin
            wr(12'(GATE0_ADDR),
               i < 5 ? 32'(1 << i) : 32'($random(seed)) & 32'h0000_001F,
               4'hF);
            repeat (40) @(posedge ref_clk);
            rd(12'(GATE0_ADDR));
        end
        // Sticky bits, partial clear, masked lane, unmapped places
        rd(12'(LATCH10_ADDR));
        wr(12'(LATCH10_ADDR), 32'h0000_0015, 4'hF);
        rd(12'(LATCH10_ADDR));
        // A coarse failure held through a full clear stays latched
        hold10 = 5'h04;
        wr(12'(LATCH10_ADDR), 32'h0000_0000, 4'hF);
        hold10 = 5'h00;
        rd(12'(LATCH10_ADDR));
        wr(12'(LATCH10_ADDR), 32'h0000_0000, 4'h0);
        rd(12'(LATCH10_ADDR));
        wr(12'h0C4, 32'h0000_001F, 4'hF);
        rd(12'h0C4);
        wr(12'h8C0, 32'h0000_0000, 4'hF);
        rd(12'h8C0);
        rd(12'(LATCH10_ADDR));
        end_sim();
    end
endmodule // tb_ref_fail_flag_masking
`default_nettype wire
